// *** include/hold_timer_if.sv ***
// interface: hold-interval timer control between controller and timer
`timescale 1ns/1ps
interface hold_timer_if;
	logic run;
	logic expired;
	modport ctl (output run, input expired);
	modport tmr (input run, output expired);
endinterface : hold_timer_if

// *** include/power_loss_pkg.sv ***
// package: constants and types for the power-loss restore controller
package power_loss_pkg;

	// ==========================================================
	// clock and hold interval
	localparam longint unsigned CLK_HZ = 200_000_000;
	localparam longint unsigned HOLD_TIME_S = 30;
	localparam longint unsigned HOLD_CYCLES = HOLD_TIME_S * CLK_HZ;
	// wide enough for 6e9 cycles
	localparam int CNT_W = 33;

	// ==========================================================
	// restore policy encodings
	typedef enum logic [1:0] {
		POL_TURN_ON = 2'h0,
		POL_REMAIN_OFF = 2'h1,
		POL_LAST_STATE = 2'h2
	} policy_t;

	// ==========================================================
	// controller states, gray coded along the usual path
	typedef enum logic [2:0] {
		ST_BOOT = 3'h0,
		ST_OFF = 3'h1,
		ST_ON = 3'h3,
		ST_WATCH = 3'h2,
		ST_DEAD = 3'h6
	} state_t;

	// ==========================================================
	// values after reset
	localparam logic [1:0] SYNC_RST = 2'h0;
	localparam logic RECORD_RST = 1'h0;

endpackage : power_loss_pkg

// *** logic/hold_timer.sv ***
// module: hold-interval timer, counts while run is high
`timescale 1ns/1ps
module hold_timer #(
	parameter longint unsigned LIMIT = power_loss_pkg::HOLD_CYCLES
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	hold_timer_if.tmr hold
);

	// ==========================================================
	// counter
	// cleared whenever run drops, so each interval starts fresh
	localparam logic [power_loss_pkg::CNT_W-1:0] LAST =
		power_loss_pkg::CNT_W'(LIMIT - 1);

	logic [power_loss_pkg::CNT_W-1:0] cnt_q;
	logic expired_q;

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			cnt_q <= '0;
		end else if (ce_i) begin
			if (!hold.run) begin
				cnt_q <= '0;
			end else if (!expired_q) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			expired_q <= 1'b0;
		end else if (ce_i) begin
			expired_q <= hold.run && (expired_q || cnt_q == LAST);
		end
	end

	assign hold.expired = expired_q;

endmodule : hold_timer

// *** logic/power_loss_restore_control.sv ***
// module: restore policy controller on the standby rail
//
// Overview of operation
// - keep watching standby rail after shutdown or loss
// - rail stable full interval means proper off
// - rail lost inside interval means AC loss
// - on restore: turn on, stay off, or last
// - interval runs only under last-state policy
// - loss soon after shutdown may record on
// - no standby rail means no restore policy
`timescale 1ns/1ps
module power_loss_restore_control #(
	parameter longint unsigned HOLD_CYCLES = power_loss_pkg::HOLD_CYCLES
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic stby_ok_i,
	input wire logic platform_on_i,
	input wire logic atx_present_i,
	input wire logic nv_last_on_i,
	input wire logic [1:0] policy_i,
	output logic power_on_req_o,
	output logic nv_wr_o,
	output logic nv_last_on_o,
	output logic proper_off_o,
	output logic ac_loss_o,
	output logic restore_done_o
);

	// ==========================================================
	// pin synchronisers
	logic [1:0] stby_sq, plat_sq, atx_sq, nv_sq;
	logic stby_s, plat_s, atx_s, nv_s;

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			stby_sq <= power_loss_pkg::SYNC_RST;
			plat_sq <= power_loss_pkg::SYNC_RST;
			atx_sq <= power_loss_pkg::SYNC_RST;
			nv_sq <= power_loss_pkg::SYNC_RST;
		end else if (ce_i) begin
			stby_sq <= {stby_sq[0], stby_ok_i};
			plat_sq <= {plat_sq[0], platform_on_i};
			atx_sq <= {atx_sq[0], atx_present_i};
			nv_sq <= {nv_sq[0], nv_last_on_i};
		end
	end

	assign stby_s = stby_sq[1];
	assign plat_s = plat_sq[1];
	assign atx_s = atx_sq[1];
	assign nv_s = nv_sq[1];

	// ==========================================================
	// policy decision
	function automatic logic restore_on(input logic [1:0] pol,
			input logic last_on);
		case (pol)
			power_loss_pkg::POL_TURN_ON: restore_on = 1'b1;
			power_loss_pkg::POL_LAST_STATE: restore_on = last_on;
			default: restore_on = 1'b0;
		endcase
	endfunction : restore_on

	// ==========================================================
	// hold timer
	hold_timer_if hold ();

	hold_timer #(
		.LIMIT(HOLD_CYCLES)
	) u_hold (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.hold(hold)
	);

	// ==========================================================
	// state machine
	power_loss_pkg::state_t state_q;
	logic [1:0] policy_q;
	logic atx_q;

	// policy is latched on restore so a change mid-interval cannot
	// cut a running hold interval short
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			policy_q <= power_loss_pkg::POL_REMAIN_OFF;
			atx_q <= 1'b0;
		end else if (ce_i && state_q == power_loss_pkg::ST_BOOT) begin
			policy_q <= policy_i;
			atx_q <= atx_s;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			state_q <= power_loss_pkg::ST_BOOT;
		end else if (ce_i) begin
			case (state_q)
				power_loss_pkg::ST_BOOT: begin
					if (stby_s) begin
						state_q <= power_loss_pkg::ST_OFF;
					end
				end
				power_loss_pkg::ST_OFF: begin
					if (!stby_s) begin
						state_q <= power_loss_pkg::ST_DEAD;
					end else if (plat_s) begin
						state_q <= power_loss_pkg::ST_ON;
					end
				end
				power_loss_pkg::ST_ON: begin
					if (!stby_s) begin
						state_q <= power_loss_pkg::ST_DEAD;
					end else if (!plat_s) begin
						if (policy_q == power_loss_pkg::POL_LAST_STATE) begin
							state_q <= power_loss_pkg::ST_WATCH;
						end else begin
							state_q <= power_loss_pkg::ST_OFF;
						end
					end
				end
				power_loss_pkg::ST_WATCH: begin
					if (!stby_s) begin
						state_q <= power_loss_pkg::ST_DEAD;
					end else if (plat_s) begin
						state_q <= power_loss_pkg::ST_ON;
					end else if (hold.expired) begin
						state_q <= power_loss_pkg::ST_OFF;
					end
				end
				power_loss_pkg::ST_DEAD: begin
					// rail back: treat as a fresh restore
					if (stby_s) begin
						state_q <= power_loss_pkg::ST_BOOT;
					end
				end
				default: state_q <= power_loss_pkg::ST_BOOT;
			endcase
		end
	end

	assign hold.run = (state_q == power_loss_pkg::ST_WATCH) && plat_s == 1'b0
		&& stby_s;

	// ==========================================================
	// restore request
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			power_on_req_o <= 1'b0;
			restore_done_o <= 1'b0;
		end else if (ce_i) begin
			power_on_req_o <= 1'b0;
			if (state_q == power_loss_pkg::ST_BOOT && stby_s) begin
				restore_done_o <= 1'b1;
				// no standby rail support: the policy is ignored
				power_on_req_o <= atx_s &&
					restore_on(policy_i, nv_s);
			end else if (state_q == power_loss_pkg::ST_DEAD) begin
				restore_done_o <= 1'b0;
			end
		end
	end

	// ==========================================================
	// non-volatile state record
	// the on state is written as soon as the platform runs; a loss
	// inside the interval leaves it on, which is accepted behaviour
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			nv_wr_o <= 1'b0;
			nv_last_on_o <= power_loss_pkg::RECORD_RST;
		end else if (ce_i) begin
			nv_wr_o <= 1'b0;
			if (state_q == power_loss_pkg::ST_OFF && stby_s && plat_s) begin
				nv_wr_o <= 1'b1;
				nv_last_on_o <= 1'b1;
			end else if (state_q == power_loss_pkg::ST_ON && stby_s
					&& !plat_s && policy_q != power_loss_pkg::POL_LAST_STATE) begin
				nv_wr_o <= 1'b1;
				nv_last_on_o <= 1'b0;
			end else if (state_q == power_loss_pkg::ST_WATCH && stby_s
					&& !plat_s && hold.expired) begin
				nv_wr_o <= 1'b1;
				nv_last_on_o <= 1'b0;
			end
		end
	end

	// ==========================================================
	// classification pulses
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			proper_off_o <= 1'b0;
			ac_loss_o <= 1'b0;
		end else if (ce_i) begin
			proper_off_o <= state_q == power_loss_pkg::ST_WATCH && stby_s
				&& !plat_s && hold.expired;
			ac_loss_o <= !stby_s && (state_q == power_loss_pkg::ST_WATCH
				|| state_q == power_loss_pkg::ST_ON);
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	a_watch_rail_loss: assert property (
		state_q == power_loss_pkg::ST_WATCH && !stby_s && ce_i
		|=> ac_loss_o && state_q == power_loss_pkg::ST_DEAD)
		else $error("rail loss during watch not classified");

	a_proper_off_cls: assert property (
		proper_off_o |-> nv_wr_o && !nv_last_on_o
		&& $past(hold.expired) && state_q == power_loss_pkg::ST_OFF)
		else $error("proper off without full interval");

	a_ac_loss_cls: assert property (
		ac_loss_o |-> !nv_wr_o && !proper_off_o
		&& state_q == power_loss_pkg::ST_DEAD)
		else $error("ac loss classification inconsistent");

	a_restore_req: assert property (
		power_on_req_o |-> $past(state_q) == power_loss_pkg::ST_BOOT
		&& restore_done_o ##1 !power_on_req_o)
		else $error("power on request outside restore");

	a_watch_policy: assert property (
		state_q == power_loss_pkg::ST_WATCH
		|-> policy_q == power_loss_pkg::POL_LAST_STATE)
		else $error("hold interval under wrong policy");

	a_watch_records_on: assert property (
		state_q == power_loss_pkg::ST_WATCH |-> nv_last_on_o)
		else $error("record not on during hold interval");

	a_no_atx_policy: assert property (
		power_on_req_o |-> atx_q)
		else $error("policy applied without standby rail");

	a_nv_on_write: assert property (
		state_q == power_loss_pkg::ST_OFF && stby_s && plat_s && ce_i
		|=> nv_wr_o && nv_last_on_o ##1 !nv_wr_o)
		else $error("on state not recorded");

	a_timer_early: assert property (
		$rose(hold.run) |-> !hold.expired [*3])
		else $error("hold timer expired too early");

	c_proper_off: cover property (proper_off_o);
	c_ac_loss_watch: cover property (
		state_q == power_loss_pkg::ST_WATCH ##1 ac_loss_o);
	c_restore_on: cover property (power_on_req_o);
	c_last_state_on: cover property (
		power_on_req_o && policy_q == power_loss_pkg::POL_LAST_STATE);

endmodule : power_loss_restore_control

// *** tb/power_loss_restore_control_tb.sv ***
// testbench: restore policy controller against the supply model
`timescale 1ns/1ps
module power_loss_restore_control_tb;
	localparam longint unsigned HOLD = 20;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic rail = 1'b0;
	logic btn = 1'b0;
	logic off = 1'b0;
	logic atx = 1'b1;
	logic ce = 1'b1;
	logic [1:0] policy = 2'h0;
	logic stby, plat, nv_rd, req, nv_wr, nv_val, proper, ac, done;
	int fails = 0;
	int compares = 0;
	int n_req = 0;
	int n_wr = 0;
	int n_prop = 0;
	int n_ac = 0;
	always #2.5 clock_i = ~clock_i;
	// ==========================================================
	// pulse counters, so short pulses are never missed
	always @(posedge clock_i) begin
		if (req === 1'b1) n_req++;
		if (nv_wr === 1'b1) n_wr++;
		if (proper === 1'b1) n_prop++;
		if (ac === 1'b1) n_ac++;
	end
	power_loss_restore_control #(.HOLD_CYCLES(HOLD)) dut (
		.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce),
		.stby_ok_i(stby), .platform_on_i(plat), .atx_present_i(atx),
		.nv_last_on_i(nv_rd), .policy_i(policy), .power_on_req_o(req),
		.nv_wr_o(nv_wr), .nv_last_on_o(nv_val), .proper_off_o(proper),
		.ac_loss_o(ac), .restore_done_o(done));
	supply_model partner (
		.clock_i(clock_i), .rail_i(rail), .btn_i(btn), .off_i(off),
		.power_on_req_i(req), .nv_wr_i(nv_wr), .nv_data_i(nv_val),
		.stby_ok_o(stby), .platform_on_o(plat), .nv_last_on_o(nv_rd));
	// ==========================================================
	// shared helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			fails++;
		end
	endtask : chk
	task automatic wait_n(input int n);
		repeat (n) @(negedge clock_i);
	endtask : wait_n
	task automatic rail_up(input logic [1:0] pol, input int exp_req);
		int r0;
		r0 = n_req;
		policy = pol;
		rail = 1'b1;
		wait_n(8);
		chk(8'(n_req - r0), 8'(exp_req));
		chk({7'h0, done}, 8'h01);
	endtask : rail_up
	task automatic rail_down();
		rail = 1'b0;
		wait_n(6);
		chk({7'h0, done}, 8'h00);
	endtask : rail_down
	task automatic press(input logic on);
		btn = on;
		off = ~on;
		wait_n(1);
		btn = 1'b0;
		off = 1'b0;
	endtask : press
	// ==========================================================
	// scenarios
	task automatic t_turn_on();
		int w0;
		int p0;
		rail_up(2'h0, 1);
		wait_n(4);
		chk({7'h0, nv_rd}, 8'h01);
		w0 = n_wr;
		p0 = n_prop;
		press(1'b0);
		wait_n(6);
		chk(8'(n_wr - w0), 8'h01);
		chk(8'(n_prop - p0), 8'h00);
		chk({7'h0, nv_rd}, 8'h00);
		rail_down();
	endtask : t_turn_on
	task automatic t_remain_off();
		rail_up(2'h1, 0);
		rail_down();
		rail_up(2'h3, 0);
		rail_down();
	endtask : t_remain_off
	task automatic t_no_atx();
		atx = 1'b0;
		wait_n(3);
		rail_up(2'h0, 0);
		rail_down();
		atx = 1'b1;
		wait_n(3);
	endtask : t_no_atx
	task automatic t_proper_off();
		int p0;
		int n;
		rail_up(2'h2, 0);
		press(1'b1);
		wait_n(5);
		chk({7'h0, nv_rd}, 8'h01);
		p0 = n_prop;
		press(1'b0);
		// freeze mid-interval: stalled cycles must not count, so the
		// verdict moves out by the frozen span, landing HOLD to HOLD + 8 live cycles after release
		wait_n(9);
		ce = 1'b0;
		wait_n(30);
		chk(8'(n_prop - p0), 8'h00);
		ce = 1'b1;
		n = 9;
		while (n_prop == p0 && n < 100) begin
			wait_n(1);
			n++;
		end
		chk({7'h0, n >= HOLD && n <= HOLD + 8}, 8'h01);
		chk({7'h0, nv_rd}, 8'h00);
	endtask : t_proper_off
	task automatic t_ac_loss();
		int a0;
		int p0;
		a0 = n_ac;
		p0 = n_prop;
		press(1'b1);
		wait_n(5);
		press(1'b0);
		wait_n(HOLD / 2);
		rail_down();
		chk(8'(n_ac - a0), 8'h01);
		chk(8'(n_prop - p0), 8'h00);
		chk({7'h0, nv_rd}, 8'h01);
		rail_up(2'h2, 1);
		rail_down();
	endtask : t_ac_loss
	// ==========================================================
	// closing and main sequence
	task automatic test_done();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done
	initial begin
		#20000;
		fails++;
		test_done();
	end
	initial begin
		wait_n(2);
		rstn_i = 1'b1;
		t_turn_on();
		t_remain_off();
		t_no_atx();
		t_proper_off();
		t_ac_loss();
		test_done();
	end
endmodule : power_loss_restore_control_tb

// *** tb/supply_model.sv ***
// partner model: standby supply, platform power and non-volatile store
`timescale 1ns/1ps
module supply_model (
	input wire logic clock_i,
	input wire logic rail_i,
	input wire logic btn_i,
	input wire logic off_i,
	input wire logic power_on_req_i,
	input wire logic nv_wr_i,
	input wire logic nv_data_i,
	output logic stby_ok_o,
	output logic platform_on_o,
	output logic nv_last_on_o
);
	logic on_q = 1'b0;
	logic nv_q = 1'b0;
	assign stby_ok_o = rail_i;
	assign platform_on_o = on_q & rail_i;
	assign nv_last_on_o = nv_q;
	// ==========================================================
	// main rails die with the standby rail, no ride-through
	always_ff @(posedge clock_i) begin
		if (!rail_i || off_i) begin
			on_q <= 1'b0;
		end else if (power_on_req_i || btn_i) begin
			on_q <= 1'b1;
		end
	end
	// ==========================================================
	// bit survives every loss of power, never reset
	always_ff @(posedge clock_i) begin
		if (nv_wr_i) begin
			nv_q <= nv_data_i;
		end
	end
endmodule : supply_model
